// ===== verilog/ucfg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ucfg_regs.svh"

module ucfg_top #(
    parameter logic [7:0] BURST_MAX = 8'hff
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ee_load,
    input wire ucfg_pkg::ucfg_image_t ee_image,
    input wire logic otp_load,
    input wire ucfg_pkg::ucfg_image_t otp_image,
    input wire logic usb_reset,
    input wire logic lite_reset,
    input wire logic rst_protect,
    input wire logic [7:0] burst_cap_value,
    output logic [7:0] tx_burst_limit,
    input wire logic core_dp,
    input wire logic core_dm,
    output logic usb2_positive_pad,
    output logic usb2_negative_pad,
    input wire logic set_dev_rwk,
    input wire logic set_func_rwk,
    input wire logic clr_dev_rwk,
    input wire logic clr_func_rwk,
    output logic dev_rwk_en,
    output logic func_rwk_en,
    output logic feature_refused,
    output logic self_powered,
    input wire logic loss_of_sync,
    input wire logic clear_bulk_stall,
    output logic bulk_out_stall,
    output logic utmi_sleep_enable,
    output logic suspend_enable,
    output logic [1:0] flags1_field,
    output logic u2_exit_fast
);

    // Byte-lane write merge, used for both writable registers.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old & ~m) | (nw & m);
    endfunction

    // Default of one image bit, or the fixed value when nothing was loaded.
    function automatic logic pick(input ucfg_pkg::ucfg_src_t src, input logic img,
                                  input logic fallback);
        return (src == ucfg_pkg::UCFG_SRC_NONE) ? fallback : img;
    endfunction

    logic usb_reset_s; // USB reset level after the pin synchroniser.
    logic wr_go;
    ucfg_pkg::ucfg_req_t wr_req;
    logic wr_ok;
    logic rd_go;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;

    ucfg_sync3 u_rst_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(usb_reset),
        .q(usb_reset_s)
    );

    ucfg_axil_slave u_bus (
        .clk(clk),
        .arst_n(arst_n),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_go(wr_go),
        .wr_req(wr_req),
        .wr_ok(wr_ok),
        .rd_go(rd_go),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    ucfg_pkg::ucfg_src_t src_r; // Source of the last loaded image.
    ucfg_pkg::ucfg_image_t img_r; // Flag bytes last loaded.
    logic ee_pwr_r; // Power bit, kept only from an EEPROM image.
    logic apply_r; // One-cycle request to load defaults after an image arrives.
    logic [31:0] cfg_r; // Configuration register.
    logic [31:0] aux_r; // Auxiliary register.

    // Image capture: an EEPROM image outranks OTP, and OTP never overwrites it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_r <= ucfg_pkg::UCFG_SRC_NONE;
            img_r <= '0;
            ee_pwr_r <= `UCFG_DEF_PWR;
        end else if (ee_load) begin
            src_r <= ucfg_pkg::UCFG_SRC_EE;
            img_r <= ee_image;
            ee_pwr_r <= ee_image.flags0[`UCFG_F0_PWR];
        end else if (otp_load) begin
            unique case (src_r)
                ucfg_pkg::UCFG_SRC_NONE,
                ucfg_pkg::UCFG_SRC_OTP: begin
                    src_r <= ucfg_pkg::UCFG_SRC_OTP;
                    img_r <= otp_image;
                end
                ucfg_pkg::UCFG_SRC_EE: begin
                    src_r <= ucfg_pkg::UCFG_SRC_EE;
                end
                default: begin
                    src_r <= ucfg_pkg::UCFG_SRC_NONE;
                end
            endcase
        end
    end

    // A fresh image becomes the live default on the following cycle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            apply_r <= 1'b0;
        end else begin
            apply_r <= ee_load || otp_load;
        end
    end

    // Restore events; protected fields skip the guarded resets but take a new image.
    logic restore;
    logic restore_prot;
    assign restore = usb_reset_s || lite_reset || apply_r;
    assign restore_prot = apply_r || ((usb_reset_s || lite_reset) && !rst_protect);

    // Register write decode; reserved and read-only bits are masked off.
    logic wr_cfg;
    logic wr_aux;
    assign wr_cfg = wr_go && (wr_req.addr == `UCFG_CFG_OFF);
    assign wr_aux = wr_go && (wr_req.addr == `UCFG_AUX_OFF);
    assign wr_ok = (wr_req.addr == `UCFG_CFG_OFF) || (wr_req.addr == `UCFG_AUX_OFF);

    // Configuration register; a restore beats a write in the same cycle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= 32'h0000_0000;
            cfg_r[`UCFG_BCE_BIT] <= `UCFG_DEF_BCE;
            cfg_r[`UCFG_SBP_BIT] <= `UCFG_DEF_SBP;
            cfg_r[`UCFG_SWAP_BIT] <= `UCFG_DEF_SWAP;
            cfg_r[`UCFG_RWK_BIT] <= `UCFG_DEF_RWK;
            cfg_r[`UCFG_PWR_BIT] <= `UCFG_DEF_PWR;
            cfg_r[`UCFG_SLP_BIT] <= `UCFG_DEF_SLP;
            cfg_r[`UCFG_U2X_BIT] <= `UCFG_DEF_U2X;
        end else if (restore) begin
            cfg_r[`UCFG_SWAP_BIT] <= pick(src_r, img_r.flags0[`UCFG_F0_SWAP],
                                          `UCFG_DEF_SWAP);
            cfg_r[`UCFG_SLP_BIT] <= pick(src_r, img_r.flags1[`UCFG_F1_SLP],
                                         `UCFG_DEF_SLP);
            cfg_r[`UCFG_U2X_BIT] <= pick(src_r, img_r.flags2[`UCFG_F2_U2X],
                                         `UCFG_DEF_U2X);
            if (restore_prot) begin
                cfg_r[`UCFG_RWK_BIT] <= pick(src_r, img_r.flags0[`UCFG_F0_RWK],
                                             `UCFG_DEF_RWK);
                cfg_r[`UCFG_PWR_BIT] <= (src_r == ucfg_pkg::UCFG_SRC_EE) ? ee_pwr_r
                                        : `UCFG_DEF_PWR;
            end
        end else if (wr_cfg) begin
            // Swap bit and bit three are outside the write mask.
            cfg_r <= merge(cfg_r, wr_req.data, wr_req.strb, `UCFG_CFG_WMASK);
        end
    end

    // Auxiliary register holding the flags-one field and the suspend enable.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_r <= 32'h0000_0000;
            aux_r[`UCFG_F1FLD_LSB +: 2] <= `UCFG_DEF_F1FLD;
            aux_r[`UCFG_SUSP_BIT] <= `UCFG_DEF_SUSP;
        end else if (restore) begin
            aux_r[`UCFG_F1FLD_LSB +: 2] <= (src_r == ucfg_pkg::UCFG_SRC_NONE) ? `UCFG_DEF_F1FLD
                                           : img_r.flags1[`UCFG_F1_FLD +: 2];
            aux_r[`UCFG_SUSP_BIT] <= pick(src_r, img_r.flags0[`UCFG_F0_SUSP],
                                          `UCFG_DEF_SUSP);
        end else if (wr_aux) begin
            aux_r <= merge(aux_r, wr_req.data, wr_req.strb, `UCFG_AUX_WMASK);
        end
    end

    // Read mux; unmapped addresses answer with an error and zero data.
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (rd_addr)
            `UCFG_CFG_OFF: rd_data = cfg_r & ~(32'h1 << `UCFG_RSVD_BIT);
            `UCFG_AUX_OFF: rd_data = aux_r;
            `UCFG_STAT_OFF: rd_data = {25'h0, dev_rwk_en, func_rwk_en, bulk_out_stall,
                                       usb_reset_s, src_r};
            default: rd_ok = 1'b0;
        endcase
    end

    // Transmit burst size; the cap value applies only while enabled, otherwise BURST_MAX.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_burst_limit <= BURST_MAX;
        end else begin
            tx_burst_limit <= cfg_r[`UCFG_BCE_BIT] ? burst_cap_value : BURST_MAX;
        end
    end

    // Pad mapping; registered so a swap change lands cleanly on both pads together.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            usb2_positive_pad <= 1'b0;
            usb2_negative_pad <= 1'b0;
        end else begin
            usb2_positive_pad <= cfg_r[`UCFG_SWAP_BIT] ? core_dm : core_dp;
            usb2_negative_pad <= cfg_r[`UCFG_SWAP_BIT] ? core_dp : core_dm;
        end
    end

    // Remote wakeup features; a set request without the capability is refused.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dev_rwk_en <= 1'b0;
            func_rwk_en <= 1'b0;
            feature_refused <= 1'b0;
        end else begin
            feature_refused <= (set_dev_rwk || set_func_rwk) && !cfg_r[`UCFG_RWK_BIT];
            if (!cfg_r[`UCFG_RWK_BIT] || usb_reset_s) begin
                dev_rwk_en <= 1'b0;
                func_rwk_en <= 1'b0;
            end else begin
                // A set arriving with its clear is kept.
                dev_rwk_en <= set_dev_rwk || (dev_rwk_en && !clr_dev_rwk);
                func_rwk_en <= set_func_rwk || (func_rwk_en && !clr_func_rwk);
            end
        end
    end

    // Reported power method and plain configuration outputs.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            self_powered <= `UCFG_DEF_PWR;
            utmi_sleep_enable <= `UCFG_DEF_SLP;
            suspend_enable <= `UCFG_DEF_SUSP;
            flags1_field <= `UCFG_DEF_F1FLD;
            u2_exit_fast <= `UCFG_DEF_U2X;
        end else begin
            self_powered <= cfg_r[`UCFG_PWR_BIT];
            utmi_sleep_enable <= cfg_r[`UCFG_SLP_BIT];
            suspend_enable <= aux_r[`UCFG_SUSP_BIT];
            flags1_field <= aux_r[`UCFG_F1FLD_LSB +: 2];
            u2_exit_fast <= cfg_r[`UCFG_U2X_BIT];
        end
    end

    // Bulk-out stall on loss of sync; a new loss beats a simultaneous clear.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bulk_out_stall <= 1'b0;
        end else if (loss_of_sync && !cfg_r[`UCFG_SBP_BIT]) begin
            bulk_out_stall <= 1'b1;
        end else if (clear_bulk_stall || usb_reset_s) begin
            bulk_out_stall <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    burst_limit_a: assert property (
        cfg_r[`UCFG_BCE_BIT] |=> tx_burst_limit == $past(burst_cap_value))
        else $error("Burst limit does not follow the cap value.");

    pad_swap_a: assert property (
        cfg_r[`UCFG_SWAP_BIT] |=> usb2_positive_pad == $past(core_dm))
        else $error("Positive pad not swapped.");

    swap_readonly_a: assert property (
        wr_cfg && !restore |=> $stable(cfg_r[`UCFG_SWAP_BIT]))
        else $error("Software changed the swap bit.");

    wakeup_gate_a: assert property (
        !cfg_r[`UCFG_RWK_BIT] && set_dev_rwk |=> !dev_rwk_en && feature_refused)
        else $error("Wakeup enabled without capability.");

    stall_set_a: assert property (
        loss_of_sync && !cfg_r[`UCFG_SBP_BIT] |=> bulk_out_stall)
        else $error("Loss of sync did not stall the pipe.");

    protect_hold_a: assert property (
        (usb_reset_s || lite_reset) && rst_protect && !apply_r
        |=> $stable(cfg_r[`UCFG_RWK_BIT]) && $stable(cfg_r[`UCFG_PWR_BIT]))
        else $error("Protected field changed on reset.");

    image_order_a: assert property (
        src_r == ucfg_pkg::UCFG_SRC_EE && otp_load |=> src_r == ucfg_pkg::UCFG_SRC_EE)
        else $error("OTP image displaced the EEPROM image.");

    fallback_a: assert property (
        lite_reset && !rst_protect && src_r == ucfg_pkg::UCFG_SRC_NONE
        |=> cfg_r[`UCFG_RWK_BIT] && !cfg_r[`UCFG_SWAP_BIT] ##1 self_powered)
        else $error("Fixed fallbacks not restored.");

    reserved_zero_a: assert property (
        rd_go && rd_addr == `UCFG_CFG_OFF |=> !rdata[`UCFG_RSVD_BIT])
        else $error("Reserved bit reads non-zero.");

endmodule

`default_nettype wire

// ===== shared/ucfg_regs.svh
`ifndef UCFG_REGS_SVH
`define UCFG_REGS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define UCFG_CFG_OFF 12'h080
`define UCFG_AUX_OFF 12'h088
`define UCFG_STAT_OFF 12'h08c

// Field positions in the configuration register.
`define UCFG_BCE_BIT 5
`define UCFG_SWAP_BIT 4
`define UCFG_RSVD_BIT 3
`define UCFG_RWK_BIT 2
`define UCFG_PWR_BIT 1
`define UCFG_SBP_BIT 0
`define UCFG_SLP_BIT 8
`define UCFG_U2X_BIT 11
// Writable bits of the configuration register.
`define UCFG_CFG_WMASK 32'h0000_0927

// Field positions in the auxiliary register.
`define UCFG_F1FLD_LSB 0
`define UCFG_SUSP_BIT 4
`define UCFG_AUX_WMASK 32'h0000_0013

// Bit positions inside the configuration flag bytes.
`define UCFG_F0_SWAP 0
`define UCFG_F0_RWK 1
`define UCFG_F0_PWR 2
`define UCFG_F0_SUSP 3
`define UCFG_F1_SLP 0
`define UCFG_F1_FLD 1
`define UCFG_F2_U2X 0

// Fixed fallbacks when no image source is available.
`define UCFG_DEF_BCE 1'b0
`define UCFG_DEF_SBP 1'b0
`define UCFG_DEF_SWAP 1'b0
`define UCFG_DEF_RWK 1'b1
`define UCFG_DEF_PWR 1'b1
`define UCFG_DEF_SLP 1'b1
`define UCFG_DEF_SUSP 1'b1
`define UCFG_DEF_F1FLD 2'h3
`define UCFG_DEF_U2X 1'b0

// Bus responses.
`define UCFG_RESP_OKAY 2'h0
`define UCFG_RESP_SLVERR 2'h2

`endif

// ===== shared/ucfg_pkg.sv
package ucfg_pkg;

    // Configuration flag bytes as delivered by the EEPROM or OTP loader.
    typedef struct packed {
        logic [7:0] flags2;
        logic [7:0] flags1;
        logic [7:0] flags0;
    } ucfg_image_t;

    // One register access passed from the bus slave to the register bank.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } ucfg_req_t;

    // Where the last loaded default image came from.
    typedef enum logic [2:0] {
        UCFG_SRC_NONE = 3'b001,
        UCFG_SRC_OTP = 3'b010,
        UCFG_SRC_EE = 3'b100
    } ucfg_src_t;

endpackage

// ===== verilog/ucfg_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; the output follows once stages two and three agree.
module ucfg_sync3 (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic d,
    output logic q
);

    // Metastability chain; the first stage feeds only the second.
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Shift the pin level through the chain.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept a change only when two settled stages agree, filtering one-cycle glitches.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= 1'b0;
        end else if (s2_r == s3_r) begin
            q <= s3_r;
        end
    end

endmodule

`default_nettype wire

// ===== verilog/ucfg_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "ucfg_regs.svh"

// AXI4-Lite slave front end; the register bank decodes and answers in the issue cycle.
module ucfg_axil_slave (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_go,
    output ucfg_pkg::ucfg_req_t wr_req,
    input wire logic wr_ok,
    output logic rd_go,
    output logic [11:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    logic aw_have_r; // Write address captured and waiting.
    logic w_have_r; // Write data captured and waiting.
    logic [11:0] aw_r;
    logic [31:0] wd_r; // Write data held for the register bank.
    logic [3:0] ws_r; // Byte strobes held with the data.

    // Address and data may arrive in either order; each is held until both are in.
    assign awready = !aw_have_r && !bvalid;
    assign wready = !w_have_r && !bvalid;
    assign wr_go = aw_have_r && w_have_r && !bvalid;
    assign wr_req = {aw_r, wd_r, ws_r};
    assign arready = !rvalid;
    assign rd_go = arvalid && arready;
    assign rd_addr = araddr;

    // Write path: capture channels, issue once, then hold the response until taken.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_r <= 12'h000;
            wd_r <= 32'h0000_0000;
            ws_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `UCFG_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_have_r <= 1'b1;
                aw_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_r <= 1'b1;
                wd_r <= wdata;
                ws_r <= wstrb;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? `UCFG_RESP_OKAY : `UCFG_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read path: one cycle from address taken to data valid.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `UCFG_RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata <= rd_ok ? rd_data : 32'h0000_0000;
            rresp <= rd_ok ? `UCFG_RESP_OKAY : `UCFG_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== test/ucfg_ee_model.sv
`timescale 1ns/1ps
`default_nettype none

// Configuration loader stand-in: hands one flag image to the block per load pulse.
module ucfg_ee_model (
    input wire logic clk,
    output logic ee_load,
    output ucfg_pkg::ucfg_image_t ee_image,
    output logic otp_load,
    output ucfg_pkg::ucfg_image_t otp_image
);
    // Both sources start idle, with filler patterns 5a5a5a and a5a5a5 on their image lines.
    initial begin
        ee_load = 1'b0;
        otp_load = 1'b0;
        ee_image = 24'h5a5a5a;
        otp_image = 24'ha5a5a5;
    end

    // One-cycle load; the image lines are inverted afterwards so a stale copy never passes.
    task automatic load(input logic from_ee, input ucfg_pkg::ucfg_image_t img);
        @(posedge clk);
        if (from_ee) begin
            ee_load <= 1'b1;
            ee_image <= img;
        end else begin
            otp_load <= 1'b1;
            otp_image <= img;
        end
        @(posedge clk);
        ee_load <= 1'b0;
        otp_load <= 1'b0;
        ee_image <= ~img;
        otp_image <= ~img;
    endtask
endmodule

`default_nettype wire

// ===== test/usb_config_low_bits_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ucfg_regs.svh"

module usb_config_low_bits_tb;
    logic clk = 1'b0, arst_n = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, flags1_field;
    logic ee_load, otp_load;
    ucfg_pkg::ucfg_image_t ee_image, otp_image;
    logic usb_reset = 1'b0, lite_reset = 1'b0, rst_protect = 1'b0, core_dp = 1'b0, core_dm = 1'b0;
    logic set_dev_rwk = 1'b0, set_func_rwk = 1'b0, clr_dev_rwk = 1'b0, clr_func_rwk = 1'b0;
    logic loss_of_sync = 1'b0, clear_bulk_stall = 1'b0;
    logic [7:0] burst_cap_value = 8'h5a, tx_burst_limit;
    logic usb2_positive_pad, usb2_negative_pad, dev_rwk_en, func_rwk_en, feature_refused;
    logic self_powered, bulk_out_stall, utmi_sleep_enable, suspend_enable, u2_exit_fast;
    int bad_count = 0, n_compared = 0, cyc = 0;
    logic [31:0] d;
    logic [1:0] r;

    ucfg_top dut_u (.clk(clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ee_load(ee_load), .ee_image(ee_image), .otp_load(otp_load), .otp_image(otp_image),
        .usb_reset(usb_reset), .lite_reset(lite_reset), .rst_protect(rst_protect),
        .burst_cap_value(burst_cap_value), .tx_burst_limit(tx_burst_limit),
        .core_dp(core_dp), .core_dm(core_dm), .usb2_positive_pad(usb2_positive_pad),
        .usb2_negative_pad(usb2_negative_pad), .set_dev_rwk(set_dev_rwk),
        .set_func_rwk(set_func_rwk), .clr_dev_rwk(clr_dev_rwk), .clr_func_rwk(clr_func_rwk),
        .dev_rwk_en(dev_rwk_en), .func_rwk_en(func_rwk_en), .feature_refused(feature_refused),
        .self_powered(self_powered), .loss_of_sync(loss_of_sync),
        .clear_bulk_stall(clear_bulk_stall), .bulk_out_stall(bulk_out_stall),
        .utmi_sleep_enable(utmi_sleep_enable), .suspend_enable(suspend_enable),
        .flags1_field(flags1_field), .u2_exit_fast(u2_exit_fast));
    ucfg_ee_model ld_u (.clk(clk), .ee_load(ee_load), .ee_image(ee_image),
        .otp_load(otp_load), .otp_image(otp_image));

    // Clock at 50 MHz.
    always #10 clk = ~clk;

    // Verdict; reached from the main sequence or the hang guard.
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Cuts a hung run short well past the expected length.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Write: address and data offered together, each dropped once taken.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    // Read: the address is held until taken, data taken at the rvalid edge.
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // Fixed fallbacks with no image loaded.
    task automatic t_reset();
        axi_rd(`UCFG_CFG_OFF, d, r);
        chk(d, 32'h0000_0106, "cfg reset");
        axi_rd(`UCFG_AUX_OFF, d, r);
        chk(d, 32'h0000_0013, "aux reset");
        chk({24'h0, tx_burst_limit}, 32'hff, "burst uncapped");
        chk({27'h0, u2_exit_fast, utmi_sleep_enable, suspend_enable, flags1_field},
            32'hf, "fallbacks");
        $display("test reset done");
    endtask

    // Access kinds, burst cap and unmapped places.
    task automatic t_write();
        axi_wr(`UCFG_CFG_OFF, 32'hffff_ffff, r);
        axi_rd(`UCFG_CFG_OFF, d, r);
        chk(d, 32'h0000_0927, "cfg all ones");
        repeat (3) @(posedge clk);
        chk({24'h0, tx_burst_limit}, 32'h5a, "burst capped");
        chk({31'h0, self_powered}, 32'h1, "self powered");
        axi_wr(12'hffc, 32'h1, r);
        chk({30'h0, r}, {30'h0, `UCFG_RESP_SLVERR}, "unmapped write");
        axi_rd(12'hffc, d, r);
        chk({30'h0, r}, {30'h0, `UCFG_RESP_SLVERR}, "unmapped read");
        $display("test write done");
    endtask

    task automatic pulse_los();
        @(posedge clk) loss_of_sync <= 1'b1;
        @(posedge clk) loss_of_sync <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Stall on loss of sync only while the disable bit is clear.
    task automatic t_stall();
        pulse_los();
        chk({31'h0, bulk_out_stall}, 32'h0, "stall disabled");
        axi_wr(`UCFG_CFG_OFF, 32'h0000_0006, r);
        pulse_los();
        chk({31'h0, bulk_out_stall}, 32'h1, "stall taken");
        @(posedge clk) clear_bulk_stall <= 1'b1;
        @(posedge clk) clear_bulk_stall <= 1'b0;
        @(posedge clk);
        chk({31'h0, bulk_out_stall}, 32'h0, "stall cleared");
        lite(1'b0);
        axi_rd(`UCFG_CFG_OFF, d, r);
        chk(d, 32'h0000_0106, "fallback restore");
        $display("test stall done");
    endtask

    task automatic wake(input logic exp_refused);
        logic seen;
        seen = 1'b0;
        @(posedge clk) begin set_dev_rwk <= 1'b1; set_func_rwk <= 1'b1; end
        @(posedge clk) begin set_dev_rwk <= 1'b0; set_func_rwk <= 1'b0; end
        repeat (4) begin
            @(posedge clk);
            if (feature_refused === 1'b1) seen = 1'b1;
        end
        chk({31'h0, seen}, {31'h0, exp_refused}, "wake refused");
        chk({30'h0, dev_rwk_en, func_rwk_en}, {30'h0, {2{~exp_refused}}}, "wake enable");
    endtask

    task automatic lite(input logic prot);
        @(posedge clk) begin lite_reset <= 1'b1; rst_protect <= prot; end
        repeat (2) @(posedge clk);
        lite_reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Image priority, restore on lite reset and reset protection.
    task automatic t_image();
        axi_wr(`UCFG_CFG_OFF, 32'h0, r);
        wake(1'b1);
        core_dp <= 1'b1;
        ld_u.load(1'b1, 24'h01_00_01);
        ld_u.load(1'b0, 24'h00_0f_0e);
        repeat (3) @(posedge clk);
        axi_rd(`UCFG_CFG_OFF, d, r);
        chk(d, 32'h0000_0810, "eeprom image");
        axi_rd(`UCFG_AUX_OFF, d, r);
        chk(d, 32'h0, "aux image");
        chk({27'h0, u2_exit_fast, utmi_sleep_enable, suspend_enable, flags1_field},
            32'h10, "image outputs");
        chk({30'h0, usb2_positive_pad, usb2_negative_pad}, 32'h1, "pads swapped");
        axi_wr(`UCFG_CFG_OFF, 32'h0000_0906, r);
        lite(1'b1);
        axi_rd(`UCFG_CFG_OFF, d, r);
        chk(d, 32'h0000_0816, "protected restore");
        lite(1'b0);
        axi_rd(`UCFG_CFG_OFF, d, r);
        chk(d, 32'h0000_0810, "full restore");
        axi_wr(`UCFG_CFG_OFF, 32'h0000_0004, r);
        wake(1'b0);
        usb_reset <= 1'b1;
        repeat (8) @(posedge clk);
        usb_reset <= 1'b0;
        repeat (8) @(posedge clk);
        axi_rd(`UCFG_CFG_OFF, d, r);
        chk(d, 32'h0000_0810, "usb restore");
        $display("test image done");
    endtask

    // Reset for 8 cycles, then the scenarios in turn.
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_write();
        t_stall();
        t_image();
        give_verdict();
    end
endmodule

`default_nettype wire
